// [tcpi_params.svh]
/*
  Constants of the three-class program interrupt block: memory
  locations, register offsets, field positions, operation codes.
  Assumes inclusion by bare name from the design file.
*/
`ifndef TCPI_PARAMS_SVH
`define TCPI_PARAMS_SVH

// ****************************************************************
// Fixed save and vector locations
// ****************************************************************
`define TCPI_PE_SAVE 15'h0010
`define TCPI_PE_VEC 15'h0011
`define TCPI_CN_SAVE 15'h0012
`define TCPI_CN_VEC 15'h0013
`define TCPI_IO_SAVE 15'h0014
`define TCPI_IO_VEC 15'h0015
`define TCPI_CC_RST 15'h0000
`define TCPI_CC_ONE 15'h0001
`define TCPI_CC_TWO 15'h0002
`define TCPI_SAVE_ZERO 10'h000

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TCPI_A_STATUS 8'h00
`define TCPI_A_IOIND 8'h04
`define TCPI_A_CNIND 8'h08
`define TCPI_A_PEIND 8'h0c
`define TCPI_A_CTRL 8'h10
`define TCPI_A_CC 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define TCPI_CN_TYPE 0
`define TCPI_CN_KREQ 1
`define TCPI_CN_KREL 2
`define TCPI_CN_STOP 3
`define TCPI_CN_OVF 4
`define TCPI_CN_CLK 5
`define TCPI_CN_BADOP 6
`define TCPI_CN_W 7
`define TCPI_PE_ADDR 0
`define TCPI_PE_MOD3 1
`define TCPI_CTRL_BLOCK 8
`define TCPI_T_BLOCK 8
`define TCPI_T_HIGH 9
`define TCPI_T_LOW 10
`define TCPI_T_EQUAL 11

// ****************************************************************
// Instruction-end operation codes and qualifiers
// ****************************************************************
`define TCPI_OP_NONE 4'h0
`define TCPI_OP_CLR_IO 4'h1
`define TCPI_OP_CLR_CN 4'h2
`define TCPI_OP_CLR_PE 4'h3
`define TCPI_OP_BLK_SET 4'h4
`define TCPI_OP_BLK_CLR 4'h5
`define TCPI_OP_RDCLK 4'h6
`define TCPI_OP_UNDEF 4'h7
`define TCPI_OP_TEST 4'h8
`define TCPI_OP_ADDSUB 4'h9
`define TCPI_OP_COMPARE 4'ha
`define TCPI_OP_DIVIDE 4'hb
`define TCPI_OP_SNS_SET 4'hc
`define TCPI_OP_SNS_CLR 4'hd
`define TCPI_NX_INC1 2'h0
`define TCPI_NX_INC2 2'h1
`define TCPI_NX_LOAD 2'h2
`define TCPI_CMP_HIGH 2'h1
`define TCPI_CMP_LOW 2'h2
`define TCPI_CMP_EQ 2'h3

`endif

// [tcpi_pkg.sv]
/*
  Types of the three-class program interrupt block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package tcpi_pkg;
  typedef enum logic [3:0] {
    TCPI_CL_NONE = 4'h1,
    TCPI_CL_IO = 4'h2,
    TCPI_CL_CONT = 4'h4,
    TCPI_CL_PE = 4'h8
  } tcpi_class_e;
endpackage
`default_nettype wire

// [tcpi_top.sv]
/*
  Three-class program interrupt logic with its indicator unit and
  instruction counter, reached by software over APB.
  Assumes the instruction sequencer pulses INSTR_END once per
  instruction with the op code and qualifiers valid in that cycle,
  and that the save word is written to memory by the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcpi_params.svh"

// Function
// RULE1 - With no error or contingency indicator, test io indicators and interrupt
// RULE2 - Io interrupt sets io mode, saves counter at 0020, jumps 0021
// RULE3 - Io indicators keep setting in io mode; no io interrupt until reset
// RULE4 - Error and contingency interrupts still taken during io mode
// RULE5 - Initiation or completion indication only when function bit 16 set
// RULE6 - Initiation on standby fetch; completion only on error-free end
// RULE7 - Without request those stay clear; faults still interrupt
// RULE8 - Block-set and block-clear ops steer a global io inhibit flag
// RULE9 - With no error indicator, contingencies interrupt unless higher modes set
// RULE10 - Contingency interrupt sets its mode, saves at 0018, jumps 0019
// RULE11 - Contingency mode blocks contingency and io interrupts until reset
// RULE12 - Console events set external contingency indicators
// RULE13 - Add carry beyond register or bad divide sets overflow
// RULE14 - Undefined op code or unready clock read sets contingency
// RULE15 - Any error indicator with error mode clear interrupts to 0016/0017
// RULE16 - A further error during error mode halts the processor
// RULE17 - Error mode blocks contingency and io interrupts until reset
// RULE18 - Wrong location accessed or absent module sets address error
// RULE19 - Bad check bits, residue failure or absent module sets modulo-3 error
// RULE20 - Counter holds 15-bit address, steps by one, two, or loads
// RULE21 - Indicator test goes on when clear and branches when set
// RULE22 - Add and subtract set equal on zero; compares set high, low, equal
// RULE23 - Saved word has counter in bits 1 to 15, zeros above
// RULE24 - Reset op clears mode and indicators; no interrupt at its end
module tcpi_top #(
  parameter int NCH = 4
) (
  input wire logic CLK, // 50 MHz clock
  input wire logic RESET, // Synchronous reset, high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic INSTR_END, // Instruction completion pulse
  input wire logic [3:0] OP_CODE, // Class of completing instruction
  input wire logic [1:0] NEXT_MODE, // Counter step or load
  input wire logic [14:0] NEXT_ADDR, // Load or branch address
  input wire logic [4:0] TEST_SEL, // Indicator tested or sense index
  input wire logic CARRY_OUT, // Add carry beyond top register
  input wire logic DIV_BAD, // Divisor not above dividend
  input wire logic RESULT_ZERO, // Add or subtract result zero
  input wire logic [1:0] CMP_RES, // Compare outcome
  input wire logic CLOCK_READY, // Addressable clock ready
  input wire logic [NCH-1:0] IO_INIT, // Spec fetched from standby
  input wire logic [NCH-1:0] IO_DONE, // Operation ended
  input wire logic [NCH-1:0] IO_FS16, // Spec bit 16 per channel
  input wire logic [NCH-1:0] IO_ERR, // Error indicator in channel
  input wire logic [NCH-1:0] IO_FAULT, // Error or fault event
  input wire logic CON_TYPE, // Console character typed, pin
  input wire logic CON_KREQ, // Keyboard request, pin
  input wire logic CON_KREL, // Keyboard release, pin
  input wire logic CON_STOP, // Program stop button, pin
  input wire logic ADDR_MISMATCH, // Accessed location differs
  input wire logic ADDR_ABSENT, // Module not installed
  input wire logic CHECK_BAD, // Wrong check bits 26 and 27
  input wire logic RESIDUE_BAD, // Adder residue check failed
  output logic [14:0] CC, // Instruction counter
  output logic SAVE_STB, // Save word write pulse
  output logic [14:0] SAVE_ADDR, // Save location
  output logic [24:0] SAVE_DATA, // Save word, bits 1 to 25
  output logic [3:0] TAKEN_CLASS, // Last interrupt class
  output logic HALT // Processor stop
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    logic [3:0] con_lvl;
    logic [NCH-1:0] io_init;
    logic [NCH-1:0] io_done;
    logic [NCH-1:0] io_fault;
    logic [`TCPI_CN_W-1:0] cont;
    logic [1:0] pe;
    logic io_mode;
    logic cont_mode;
    logic pe_mode;
    logic io_block;
    logic halt;
    logic [7:0] sense;
    logic cmp_h;
    logic cmp_l;
    logic cmp_e;
    logic [14:0] cc;
    logic save_stb;
    logic [14:0] save_addr;
    logic [24:0] save_data;
    tcpi_pkg::tcpi_class_e last;
    logic [31:0] prdata;
    logic err;
  } tcpi_state_s;

  tcpi_state_s s;
  tcpi_state_s next_s;

  // Set wins over a clear arriving in the same cycle
  function automatic logic [15:0] tcpi_upd(input logic [15:0] q,
      input logic clr, input logic [15:0] set);
    tcpi_upd = clr ? set : (q | set);
  endfunction

  logic ie;
  logic [3:0] con_rise;
  logic [NCH-1:0] set_init;
  logic [NCH-1:0] set_done;
  logic [`TCPI_CN_W-1:0] set_cn;
  logic [1:0] set_pe;
  logic clr_io;
  logic clr_cn;
  logic clr_pe;
  logic reset_op;
  logic any_pe;
  logic any_cn;
  logic any_io;
  logic take_pe;
  logic take_cn;
  logic take_io;
  logic [15:0] tvec;
  logic [14:0] cc_seq;
  logic wr;
  logic [15:0] io_init_u;
  logic [15:0] io_done_u;
  logic [15:0] io_fault_u;
  logic [15:0] cn_u;
  logic [15:0] pe_u;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    ie = INSTR_END & ~s.halt;
    // Console pins: three flops, change counts when second and third agree
    next_s.c1 = {CON_STOP, CON_KREL, CON_KREQ, CON_TYPE};
    next_s.c2 = s.c1;
    next_s.c3 = s.c2;
    next_s.con_lvl = (s.c2 & s.c3) | (s.con_lvl & (s.c2 | s.c3));
    con_rise = s.c2 & s.c3 & ~s.con_lvl;

    set_init = IO_INIT & IO_FS16; // RULE5 RULE6 RULE7
    set_done = IO_DONE & IO_FS16 & ~IO_ERR; // RULE5 RULE6 RULE7
    set_cn = '0;
    set_cn[`TCPI_CN_TYPE] = con_rise[`TCPI_CN_TYPE]; // RULE12
    set_cn[`TCPI_CN_KREQ] = con_rise[`TCPI_CN_KREQ]; // RULE12
    set_cn[`TCPI_CN_KREL] = con_rise[`TCPI_CN_KREL]; // RULE12
    set_cn[`TCPI_CN_STOP] = con_rise[`TCPI_CN_STOP]; // RULE12
    set_cn[`TCPI_CN_OVF] = ie & (((OP_CODE == `TCPI_OP_ADDSUB) & CARRY_OUT)
        | ((OP_CODE == `TCPI_OP_DIVIDE) & DIV_BAD)); // RULE13
    set_cn[`TCPI_CN_CLK] = ie & (OP_CODE == `TCPI_OP_RDCLK)
        & ~CLOCK_READY; // RULE14
    set_cn[`TCPI_CN_BADOP] = ie & (OP_CODE == `TCPI_OP_UNDEF); // RULE14
    set_pe[`TCPI_PE_ADDR] = ADDR_MISMATCH | ADDR_ABSENT; // RULE18
    set_pe[`TCPI_PE_MOD3] = CHECK_BAD | RESIDUE_BAD | ADDR_ABSENT; // RULE19

    // A class reset never takes an interrupt at its own end, so the
    // handler can return through the saved word without re-entry
    clr_io = ie & (OP_CODE == `TCPI_OP_CLR_IO);
    clr_cn = ie & (OP_CODE == `TCPI_OP_CLR_CN);
    clr_pe = ie & (OP_CODE == `TCPI_OP_CLR_PE);
    reset_op = clr_io | clr_cn | clr_pe; // RULE24

    // Conditions raised by the completing instruction count at its end
    any_pe = |(s.pe | set_pe);
    any_cn = |(s.cont | set_cn);
    any_io = |(s.io_init | s.io_done | s.io_fault | set_init | set_done
        | IO_FAULT);
    // Each lower class also needs the higher indicators clear, so one
    // instruction end takes at most one class
    take_pe = ie & ~reset_op & any_pe & ~s.pe_mode; // RULE15
    take_cn = ie & ~reset_op & ~any_pe & any_cn & ~s.pe_mode
        & ~s.cont_mode; // RULE9 RULE11 RULE17
    take_io = ie & ~reset_op & ~any_pe & ~any_cn & any_io & ~s.pe_mode
        & ~s.cont_mode & ~s.io_mode & ~s.io_block; // RULE1 RULE3 RULE8

    // Indicators keep setting in every mode; reset ops clear their class
    io_init_u = tcpi_upd(16'(s.io_init), clr_io, 16'(set_init));
    io_done_u = tcpi_upd(16'(s.io_done), clr_io, 16'(set_done));
    io_fault_u = tcpi_upd(16'(s.io_fault), clr_io, 16'(IO_FAULT)); // RULE7
    cn_u = tcpi_upd(16'(s.cont), clr_cn, 16'(set_cn));
    pe_u = tcpi_upd(16'(s.pe), clr_pe, 16'(set_pe));
    next_s.io_init = io_init_u[NCH-1:0]; // RULE3 RULE24
    next_s.io_done = io_done_u[NCH-1:0]; // RULE3 RULE24
    next_s.io_fault = io_fault_u[NCH-1:0]; // RULE3 RULE24
    next_s.cont = cn_u[`TCPI_CN_W-1:0]; // RULE11 RULE24
    next_s.pe = pe_u[1:0]; // RULE17 RULE24

    // Mode flags
    // A take and a clear of one class never meet: reset ops take nothing
    next_s.pe_mode = take_pe | (s.pe_mode & ~clr_pe); // RULE15 RULE24
    next_s.cont_mode = take_cn | (s.cont_mode & ~clr_cn); // RULE10 RULE24
    next_s.io_mode = take_io | (s.io_mode & ~clr_io); // RULE2 RULE24
    // A new error while already in error mode stops the processor
    // Halt is sticky; only RESET brings the sequencer back
    if (s.pe_mode & (|set_pe)) begin
      next_s.halt = 1'b1; // RULE16
    end

    // Register writes take effect in the access phase
    // Program ops below are applied later and win a same-cycle clash
    wr = PSEL & PENABLE & PWRITE;
    if (wr & (PADDR == `TCPI_A_CTRL)) begin
      next_s.sense = PWDATA[7:0];
      next_s.io_block = PWDATA[`TCPI_CTRL_BLOCK];
    end
    if (ie & (OP_CODE == `TCPI_OP_BLK_CLR)) begin
      next_s.io_block = 1'b0; // RULE8
    end
    if (ie & (OP_CODE == `TCPI_OP_BLK_SET)) begin
      next_s.io_block = 1'b1; // RULE8
    end
    if (ie & (OP_CODE == `TCPI_OP_SNS_CLR)) begin
      next_s.sense[TEST_SEL[2:0]] = 1'b0;
    end
    if (ie & (OP_CODE == `TCPI_OP_SNS_SET)) begin
      next_s.sense[TEST_SEL[2:0]] = 1'b1;
    end

    // Comparison indicators
    if (ie & (OP_CODE == `TCPI_OP_ADDSUB)) begin
      next_s.cmp_e = RESULT_ZERO; // RULE22
    end
    if (ie & (OP_CODE == `TCPI_OP_COMPARE)) begin
      next_s.cmp_h = (CMP_RES == `TCPI_CMP_HIGH); // RULE22
      next_s.cmp_l = (CMP_RES == `TCPI_CMP_LOW); // RULE22
      next_s.cmp_e = (CMP_RES == `TCPI_CMP_EQ); // RULE22
    end

    // Program-testable indicators, indexed by TEST_SEL
    // Indices outside the table read as clear, so those tests never branch
    tvec = '0;
    tvec[7:0] = s.sense;
    tvec[`TCPI_T_BLOCK] = s.io_block;
    tvec[`TCPI_T_HIGH] = s.cmp_h;
    tvec[`TCPI_T_LOW] = s.cmp_l;
    tvec[`TCPI_T_EQUAL] = s.cmp_e;

    // Address of the next instruction
    // Mode 3 is unused and steps by one like mode 0
    case (NEXT_MODE)
      `TCPI_NX_INC1: cc_seq = s.cc + `TCPI_CC_ONE; // RULE20
      `TCPI_NX_INC2: cc_seq = s.cc + `TCPI_CC_TWO; // RULE20
      `TCPI_NX_LOAD: cc_seq = NEXT_ADDR; // RULE20
      default: cc_seq = s.cc + `TCPI_CC_ONE;
    endcase
    if (OP_CODE == `TCPI_OP_TEST) begin
      cc_seq = (tvec[TEST_SEL[3:0]] & ~TEST_SEL[4]) ? NEXT_ADDR
          : s.cc + `TCPI_CC_ONE; // RULE21
    end

    // The save word tracks the next address even when nothing is taken
    next_s.save_stb = 1'b0;
    if (ie) begin
      next_s.cc = cc_seq; // RULE20
      next_s.save_data = {`TCPI_SAVE_ZERO, cc_seq}; // RULE23
    end
    if (take_pe) begin
      next_s.save_stb = 1'b1;
      next_s.save_addr = `TCPI_PE_SAVE; // RULE15
      next_s.cc = `TCPI_PE_VEC; // RULE15
      next_s.last = tcpi_pkg::TCPI_CL_PE;
    end else if (take_cn) begin
      next_s.save_stb = 1'b1;
      next_s.save_addr = `TCPI_CN_SAVE; // RULE10
      next_s.cc = `TCPI_CN_VEC; // RULE10
      next_s.last = tcpi_pkg::TCPI_CL_CONT;
    end else if (take_io) begin
      next_s.save_stb = 1'b1;
      next_s.save_addr = `TCPI_IO_SAVE; // RULE2
      next_s.cc = `TCPI_IO_VEC; // RULE2
      next_s.last = tcpi_pkg::TCPI_CL_IO;
    end
    // Io mode never gates the two higher classes
    if (s.io_mode & take_pe) begin
      next_s.pe_mode = 1'b1; // RULE4
    end

    // Read data is captured in the setup cycle, answered in access
    // Unmapped offsets read as zero and raise the error flag
    if (PSEL & ~PENABLE) begin
      next_s.err = 1'b0;
      next_s.prdata = '0;
      case (PADDR)
        `TCPI_A_STATUS: next_s.prdata = 32'({s.last, s.halt, s.io_block,
            s.pe_mode, s.cont_mode, s.io_mode});
        `TCPI_A_IOIND: next_s.prdata = 32'({s.io_fault, s.io_done,
            s.io_init});
        `TCPI_A_CNIND: next_s.prdata = 32'(s.cont);
        `TCPI_A_PEIND: next_s.prdata = 32'(s.pe);
        `TCPI_A_CTRL: next_s.prdata = 32'({s.io_block, s.sense});
        `TCPI_A_CC: next_s.prdata = 32'(s.cc);
        default: next_s.err = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s <= '0;
      s.cc <= `TCPI_CC_RST;
      // The class code has a non-zero encoding for none
      s.last <= tcpi_pkg::TCPI_CL_NONE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // No wait states: every access phase completes at once
  assign PREADY = PSEL & PENABLE;
  assign PRDATA = s.prdata;
  assign PSLVERR = PSEL & PENABLE & s.err;
  assign CC = s.cc;
  assign SAVE_STB = s.save_stb;
  assign SAVE_ADDR = s.save_addr;
  assign SAVE_DATA = s.save_data;
  assign TAKEN_CLASS = s.last;
  assign HALT = s.halt;

endmodule
`default_nettype wire

// [tcpi_top_sva.sv]
/*
  Checker of the interrupt block, watching the top module's ports.
  Assumes it is bound into tcpi_top from the testbench top file.
*/
`timescale 1ns/1ns
`default_nettype none
module tcpi_chk (
  input wire logic CLK, // clock
  input wire logic RESET, // sync reset
  input wire logic INSTR_END, // instruction end
  input wire logic [3:0] OP_CODE, // op class
  input wire logic [1:0] NEXT_MODE, // counter step
  input wire logic [14:0] NEXT_ADDR, // load target
  input wire logic ADDR_MISMATCH, // address error
  input wire logic ADDR_ABSENT, // absent module
  input wire logic CHECK_BAD, // check bits
  input wire logic RESIDUE_BAD, // residue check
  input wire logic [14:0] CC, // counter
  input wire logic SAVE_STB, // save pulse
  input wire logic [14:0] SAVE_ADDR, // save location
  input wire logic [24:0] SAVE_DATA, // save word
  input wire logic [3:0] TAKEN_CLASS, // class taken
  input wire logic HALT // stopped
);
  // **********
  // Properties
  // **********
  logic any_err;
  assign any_err = ADDR_MISMATCH | ADDR_ABSENT | CHECK_BAD | RESIDUE_BAD;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_pe_vector: assert property (
    SAVE_STB && SAVE_ADDR == 15'h0010 |-> CC == 15'h0011
    && TAKEN_CLASS == 4'h8) else $error("error vector wrong");
  a_cn_vector: assert property (
    SAVE_STB && SAVE_ADDR == 15'h0012 |-> CC == 15'h0013
    && TAKEN_CLASS == 4'h4) else $error("contingency vector wrong");
  a_io_vector: assert property (
    SAVE_STB && SAVE_ADDR == 15'h0014 |-> CC == 15'h0015
    && TAKEN_CLASS == 4'h2) else $error("io vector wrong");
  a_save_cause: assert property (
    SAVE_STB |-> $past(INSTR_END) && !$past(HALT))
    else $error("save without instruction end");
  a_save_zero: assert property (
    SAVE_STB |-> SAVE_DATA[24:15] == 10'h000)
    else $error("save word upper bits set");
  a_halt_hold: assert property (HALT |=> HALT)
    else $error("halt released");
  a_halt_cause: assert property ($rose(HALT) |-> $past(any_err))
    else $error("halt without error");
  a_reset_quiet: assert property (
    INSTR_END && !HALT && OP_CODE inside {4'h1, 4'h2, 4'h3} |=> !SAVE_STB)
    else $error("interrupt at class reset end");
  a_cc_two: assert property (
    INSTR_END && !HALT && OP_CODE == 4'h0 && NEXT_MODE == 2'h1
    |=> SAVE_STB || CC == $past(CC) + 15'h0002)
    else $error("counter step of two wrong");
  a_cc_load: assert property (
    INSTR_END && !HALT && OP_CODE == 4'h0 && NEXT_MODE == 2'h2
    |=> SAVE_STB || CC == $past(NEXT_ADDR)) else $error("load wrong");
  c_io: cover property (SAVE_STB && TAKEN_CLASS == 4'h2);
  c_cn: cover property (SAVE_STB && TAKEN_CLASS == 4'h4);
  c_pe: cover property (SAVE_STB && TAKEN_CLASS == 4'h8);
  c_halt: cover property ($rose(HALT));
endmodule
`default_nettype wire

// [tcpi_far.sv]
/*
  Far-side model: input-output synchronizers and operator console.
  Assumes its tasks are called from the bench's clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module tcpi_far #(
  parameter int NCH = 4
) (
  input wire logic clk, // clock
  output logic [NCH-1:0] io_init, // spec fetched
  output logic [NCH-1:0] io_done, // operation ended
  output logic [NCH-1:0] io_fs16, // spec bit 16
  output logic [NCH-1:0] io_err, // error level
  output logic [NCH-1:0] io_fault, // fault event
  output logic [3:0] con // console pins
);
  initial begin
    {io_init, io_done, io_fs16, io_err, io_fault} = '0;
    con = 4'h0;
  end
  // Levels are inverted after the pulse so a late sample cannot pass
  task io_evt(input logic [NCH-1:0] ini, dn, fs, er, ft);
    @(posedge clk);
    io_init <= ini;
    io_done <= dn;
    io_fs16 <= fs;
    io_err <= er;
    io_fault <= ft;
    @(posedge clk);
    {io_init, io_done, io_fault} <= '0;
    {io_fs16, io_err} <= {~fs, ~er};
  endtask
  // Pins are asynchronous: held long enough for the synchronizer
  task con_evt(input int k);
    @(posedge clk);
    con[k] <= 1'b1;
    repeat (4) @(posedge clk);
    con[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [test_three_class_program_interrupt.sv]
/*
  Self-checking bench of the three-class interrupt block.
  Assumes the checker and far-side model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcpi_params.svh"
module test_three_class_program_interrupt;
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] md;
    logic [4:0] sel;
    logic zr;
    logic [1:0] cmp;
    logic ld;
  } tcpi_row_s;
  logic CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, INSTR_END = 1'b0, RESULT_ZERO = 1'b0;
  logic CARRY_OUT = 1'b0, DIV_BAD = 1'b0, CLOCK_READY = 1'b1;
  logic ADDR_MISMATCH = 1'b0, ADDR_ABSENT = 1'b0, CHECK_BAD = 1'b0;
  logic RESIDUE_BAD = 1'b0, PREADY, PSLVERR, SAVE_STB, HALT, er;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [3:0] OP_CODE = 4'h0, TAKEN_CLASS, CON;
  logic [3:0] IO_INIT, IO_DONE, IO_FS16, IO_ERR, IO_FAULT;
  logic [1:0] NEXT_MODE = 2'h0, CMP_RES = 2'h0;
  logic [14:0] NEXT_ADDR = 15'h0, CC, SAVE_ADDR, cc_m = 15'h0, nx;
  logic [4:0] TEST_SEL = 5'h00;
  logic [24:0] SAVE_DATA;
  int fails = 0, n_compared = 0, n;
  tcpi_row_s rows [19] = '{
    '{4'h0, 2'h0, 5'h00, 1'b0, 2'h0, 1'b0},
    '{4'h0, 2'h1, 5'h00, 1'b0, 2'h0, 1'b0},
    '{4'h0, 2'h2, 5'h00, 1'b0, 2'h0, 1'b1},
    '{4'h0, 2'h3, 5'h00, 1'b0, 2'h0, 1'b0},
    '{4'hc, 2'h0, 5'h02, 1'b0, 2'h0, 1'b0},
    '{4'h8, 2'h0, 5'h02, 1'b0, 2'h0, 1'b1},
    '{4'hd, 2'h0, 5'h02, 1'b0, 2'h0, 1'b0},
    '{4'h8, 2'h0, 5'h02, 1'b0, 2'h0, 1'b0},
    '{4'h9, 2'h0, 5'h00, 1'b1, 2'h0, 1'b0},
    '{4'h8, 2'h0, 5'h0b, 1'b0, 2'h0, 1'b1},
    '{4'h9, 2'h0, 5'h00, 1'b0, 2'h0, 1'b0},
    '{4'h8, 2'h0, 5'h0b, 1'b0, 2'h0, 1'b0},
    '{4'ha, 2'h0, 5'h00, 1'b0, 2'h1, 1'b0},
    '{4'h8, 2'h0, 5'h09, 1'b0, 2'h0, 1'b1},
    '{4'ha, 2'h0, 5'h00, 1'b0, 2'h2, 1'b0},
    '{4'h8, 2'h0, 5'h0a, 1'b0, 2'h0, 1'b1},
    '{4'h8, 2'h0, 5'h08, 1'b0, 2'h0, 1'b0},
    '{4'ha, 2'h0, 5'h00, 1'b0, 2'h3, 1'b0},
    '{4'h8, 2'h0, 5'h0b, 1'b0, 2'h0, 1'b1}};
  always #10 CLK = ~CLK;
  tcpi_top #(.NCH(4)) u_dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .INSTR_END, .OP_CODE,
    .NEXT_MODE, .NEXT_ADDR, .TEST_SEL, .CARRY_OUT, .DIV_BAD,
    .RESULT_ZERO, .CMP_RES, .CLOCK_READY, .IO_INIT, .IO_DONE,
    .IO_FS16, .IO_ERR, .IO_FAULT, .CON_TYPE(CON[0]), .CON_KREQ(CON[1]),
    .CON_KREL(CON[2]), .CON_STOP(CON[3]), .ADDR_MISMATCH, .ADDR_ABSENT,
    .CHECK_BAD, .RESIDUE_BAD, .CC, .SAVE_STB, .SAVE_ADDR, .SAVE_DATA,
    .TAKEN_CLASS, .HALT);
  tcpi_far #(.NCH(4)) u_far (.clk(CLK), .io_init(IO_INIT),
    .io_done(IO_DONE), .io_fs16(IO_FS16), .io_err(IO_ERR),
    .io_fault(IO_FAULT), .con(CON));
  // **********
  // Tasks
  // **********
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_compared++;
    if (seen !== ex) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) begin
      fails++;
      summarize;
    end
    rd = PRDATA;
    er = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  // A save location of 7fff means a stop is expected instead
  task ie(input logic [3:0] op, input logic [14:0] x, input logic [14:0] sav,
      input logic [3:0] e);
    @(posedge CLK);
    {INSTR_END, OP_CODE} <= {1'b1, op};
    {ADDR_MISMATCH, ADDR_ABSENT, CHECK_BAD, RESIDUE_BAD} <= e;
    @(posedge CLK);
    INSTR_END <= 1'b0;
    {ADDR_MISMATCH, ADDR_ABSENT, CHECK_BAD, RESIDUE_BAD} <= 4'h0;
    #1;
    if (sav == 15'h7fff) begin
      chk("halt", HALT, 32'h1);
    end else if (sav == 15'h0) begin
      chk("no save", SAVE_STB, 32'h0);
      chk("counter", CC, x);
      cc_m = x;
    end else begin
      chk("save", {SAVE_STB, SAVE_ADDR}, {1'b1, sav});
      chk("save word", SAVE_DATA, x);
      chk("vector", CC, sav + 15'h1);
      cc_m = sav + 15'h1;
    end
  endtask
  // **********
  // Sequence
  // **********
  initial begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, i == 0 ? 32'h20 : 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b1, `TCPI_A_CTRL, 32'h0ff);
    apb(1'b0, `TCPI_A_CTRL, 32'h0);
    chk("control", rd, 32'h0ff);
    $display("test registers done");
    foreach (rows[i]) begin
      @(posedge CLK);
      {NEXT_MODE, TEST_SEL} <= {rows[i].md, rows[i].sel};
      {RESULT_ZERO, CMP_RES} <= {rows[i].zr, rows[i].cmp};
      NEXT_ADDR <= 15'(i * 16 + 256);
      nx = cc_m + (rows[i].md == 2'h1 ? 15'h2 : 15'h1);
      ie(rows[i].op, rows[i].ld ? 15'(i * 16 + 256) : nx, 15'h0, 4'h0);
    end
    @(posedge CLK);
    {NEXT_MODE, TEST_SEL} <= {2'h0, 5'h00};
    $display("test counter done");
    ie(`TCPI_OP_BLK_SET, cc_m + 15'h1, 15'h0, 4'h0);
    apb(1'b0, `TCPI_A_STATUS, 32'h0);
    chk("block flag", rd[3], 32'h1);
    ie(`TCPI_OP_BLK_CLR, cc_m + 15'h1, 15'h0, 4'h0);
    u_far.io_evt(4'h1, 4'h2, 4'h1, 4'h0, 4'h0);
    apb(1'b0, `TCPI_A_IOIND, 32'h0);
    chk("io indicators", rd, 32'h1);
    apb(1'b1, `TCPI_A_CTRL, 32'h100);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0, 4'h0);
    apb(1'b1, `TCPI_A_CTRL, 32'h0);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0014, 4'h0);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0, 4'h0);
    u_far.io_evt(4'h0, 4'h0, 4'h0, 4'h4, 4'h4);
    apb(1'b0, `TCPI_A_IOIND, 32'h0);
    chk("io fault", rd, 32'h401);
    $display("test io done");
    u_far.con_evt(1);
    apb(1'b0, `TCPI_A_CNIND, 32'h0);
    chk("console", rd, 32'h2);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0012, 4'h0);
    ie(`TCPI_OP_CLR_CN, cc_m + 15'h1, 15'h0, 4'h0);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0, 4'h0);
    ie(`TCPI_OP_CLR_IO, cc_m + 15'h1, 15'h0, 4'h0);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0, 4'h0);
    ie(`TCPI_OP_UNDEF, cc_m + 15'h1, 15'h0012, 4'h0);
    ie(`TCPI_OP_NONE, cc_m + 15'h1, 15'h0010, 4'h8);
    ie(`TCPI_OP_NONE, 15'h0, 15'h7fff, 4'h2);
    cc_m = CC;
    ie(`TCPI_OP_NONE, 15'h0, 15'h7fff, 4'h0);
    chk("frozen", CC, cc_m);
    $display("test classes done");
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    chk("after reset", {HALT, TAKEN_CLASS, CC}, {1'b0, 4'h1, 15'h0});
    $display("test reset done");
    @(posedge CLK);
    {CARRY_OUT, DIV_BAD, CLOCK_READY} <= 3'b100;
    ie(`TCPI_OP_DIVIDE, 15'h1, 15'h0, 4'h0);
    ie(`TCPI_OP_ADDSUB, cc_m + 15'h1, 15'h0012, 4'h0);
    ie(`TCPI_OP_RDCLK, cc_m + 15'h1, 15'h0, 4'h0);
    apb(1'b0, `TCPI_A_CNIND, 32'h0);
    chk("internal", rd, 32'h30);
    $display("test internal done");
    summarize;
  end
endmodule
bind tcpi_top tcpi_chk u_chk (.CLK, .RESET, .INSTR_END, .OP_CODE,
  .NEXT_MODE, .NEXT_ADDR, .ADDR_MISMATCH, .ADDR_ABSENT, .CHECK_BAD,
  .RESIDUE_BAD, .CC, .SAVE_STB, .SAVE_ADDR, .SAVE_DATA, .TAKEN_CLASS,
  .HALT);
`default_nettype wire
